// *** tcc_pins.sv ***
`default_nettype none
module tcc_pins (
    input  wire logic core_clk,
    output logic      cap_pin,
    output logic      ext_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cap_pin = 1'b0;
        ext_pin = 1'b0;
    end
    // set the capture level, then hold it for cyc edges
    task automatic cap_hold(input logic lvl, input int cyc);
        @(posedge core_clk);
        cap_pin <= lvl;
        repeat (cyc) @(posedge core_clk);
    endtask
    // full pulses on the count pin
    // high and low kept long enough to pass the 2-ff sync
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge core_clk);
            ext_pin <= 1'b1;
            repeat (4) @(posedge core_clk);
            ext_pin <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

// *** tcc_pkg.sv ***
`default_nettype none
package tcc_pkg;
    localparam int AW = 4;
    localparam int DW = 8;
    localparam int CW = 16;
    localparam int PW = 10;
    localparam int FILT_N = 4;
    // ---------------------------------------------
    // register offsets
    // ---------------------------------------------
    localparam logic [AW-1:0] A_CTRL_A = 4'h0;
    localparam logic [AW-1:0] A_CTRL_B = 4'h1;
    localparam logic [AW-1:0] A_FORCE  = 4'h2;
    localparam logic [AW-1:0] A_IMSK   = 4'h3;
    localparam logic [AW-1:0] A_FLAG   = 4'h4;
    localparam logic [AW-1:0] A_SRC    = 4'h5;
    localparam logic [AW-1:0] A_CNT_L  = 4'h6;
    localparam logic [AW-1:0] A_CNT_H  = 4'h7;
    localparam logic [AW-1:0] A_ICR_L  = 4'h8;
    localparam logic [AW-1:0] A_ICR_H  = 4'h9;
    localparam logic [AW-1:0] A_OCR_L  = 4'ha;
    // ---------------------------------------------
    // fields and masks
    // ---------------------------------------------
    localparam int B_FILT = 7;
    localparam int B_EDGE = 6;
    localparam int B_WGMH = 3;
    localparam int B_FOC0 = 7;
    localparam int I_CAP  = 5;
    localparam int I_OCA  = 1;
    localparam int I_OVF  = 0;
    localparam logic [DW-1:0] CTRL_B_WMASK = 8'hdf;
    localparam logic [DW-1:0] FLAG_MASK    = 8'h2f;
    localparam logic [DW-1:0] RST_8        = 8'h00;
    localparam logic [CW-1:0] RST_16       = 16'h0000;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_D64  = 3'h3;
    localparam logic [2:0] CS_D256 = 3'h4;
    localparam logic [2:0] CS_D1K  = 3'h5;
    localparam logic [2:0] CS_EXTF = 3'h6;
    localparam logic [2:0] CS_EXTR = 3'h7;
    localparam logic [PW-1:0] PM_8   = 10'h007;
    localparam logic [PW-1:0] PM_64  = 10'h03f;
    localparam logic [PW-1:0] PM_256 = 10'h0ff;
    localparam logic [PW-1:0] PM_1K  = 10'h3ff;
    localparam logic [3:0] WGM_NORM = 4'h0;
    localparam logic [3:0] WGM_CTCA = 4'h4;
    localparam logic [3:0] WGM_CTCI = 4'hc;
    localparam logic [CW-1:0] TOP_8  = 16'h00ff;
    localparam logic [CW-1:0] TOP_9  = 16'h01ff;
    localparam logic [CW-1:0] TOP_10 = 16'h03ff;
    localparam logic [CW-1:0] TOP_MX = 16'hffff;
    localparam logic [1:0] COM_TGL = 2'h1;
    localparam logic [1:0] COM_CLR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
endpackage
`default_nettype wire

// *** tcc_timer16.sv ***
// Chosen here: the strobed register port and the register offsets.
`default_nettype none
module tcc_timer16
    import tcc_pkg::*;
#(
    parameter bit HAS_CMP_SRC = 1'b1
) (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          wr_stb,
    input  wire logic          rd_stb,
    output logic      [DW-1:0] rdata,
    input  wire logic          capture_input_pin,
    input  wire logic          comparator_out,
    input  wire logic          external_count_pin,
    input  wire logic          global_irq_enable,
    input  wire logic [DW-1:0] irq_ack,
    output logic      [DW-1:0] irq_req,
    output logic      [2:0]    compare_output_pin,
    output logic      [2:0]    compare_output_oe
);
    // ---------------------------------------------
    // registers
    // ---------------------------------------------
    logic [DW-1:0] ctrl_a_reg;
    logic [DW-1:0] ctrl_b_reg;
    logic [DW-1:0] imsk_reg;
    logic [DW-1:0] flag_reg;
    logic          src_reg;
    logic [DW-1:0] temp_reg;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] icr_reg;
    logic [CW-1:0] ocr_reg [3];
    logic [PW-1:0] psc_reg;
    logic          block_reg;
    logic [DW-1:0] rdata_reg;
    logic [2:0]    oc_reg;
    logic          ext_s1, ext_s2, ext_prev;
    logic          cap_s1, cap_s2, cmp_s1, cmp_s2;
    logic [FILT_N-1:0] hist_reg;
    logic          filt_reg, filt_prev;
    logic [3:0]    wgm;
    logic [2:0]    cs;
    logic [CW-1:0] top;
    logic          tick, non_pwm, icr_top, cnt_wr, cap_src, cap_evt, at_top, ocr_lo_rd;
    logic [2:0]    match_v, force_v;
    logic [DW-1:0] set_v, clr_v, ocr_hi;

    assign wgm     = {ctrl_b_reg[B_WGMH+1:B_WGMH], ctrl_a_reg[1:0]};
    assign cs      = ctrl_b_reg[2:0];
    assign non_pwm = (wgm == WGM_NORM) || (wgm == WGM_CTCA) || (wgm == WGM_CTCI);
    assign icr_top = wgm[3] && !wgm[0] && (wgm != WGM_CTCA);
    assign cnt_wr  = wr_stb && (addr == A_CNT_L);
    assign rdata   = rdata_reg;

    // ---------------------------------------------
    // top value per waveform mode
    // ---------------------------------------------
    always_comb begin
        case (wgm)
            4'h1, 4'h5: top = TOP_8;
            4'h2, 4'h6: top = TOP_9;
            4'h3, 4'h7: top = TOP_10;
            4'h4, 4'h9, 4'hb, 4'hf: top = ocr_reg[0];
            4'h8, 4'ha, 4'hc, 4'he: top = icr_reg;
            default: top = TOP_MX;
        endcase
    end
    assign at_top = (cnt_reg == top);

    // ---------------------------------------------
    // clock source and prescaler
    // ---------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            psc_reg <= '0;
        end else begin
            psc_reg <= psc_reg + 1'b1;
        end
    end

    // pin is sampled, not gated by direction, so software may toggle it
    // pin counts only when cs selects CS_EXTF or CS_EXTR
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_s1   <= 1'b0;
            ext_s2   <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_s1   <= external_count_pin;
            ext_s2   <= ext_s1;
            ext_prev <= ext_s2;
        end
    end

    always_comb begin
        case (cs)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (psc_reg & PM_8) == PM_8;
            CS_D64:  tick = (psc_reg & PM_64) == PM_64;
            CS_D256: tick = (psc_reg & PM_256) == PM_256;
            CS_D1K:  tick = (psc_reg & PM_1K) == PM_1K;
            CS_EXTF: tick = ext_prev && !ext_s2;
            CS_EXTR: tick = !ext_prev && ext_s2;
            default: tick = 1'b0;
        endcase
    end

    // ---------------------------------------------
    // counter
    // ---------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_reg <= RST_16;
        end else if (cnt_wr) begin
            cnt_reg <= {temp_reg, wdata};
        end else if (tick) begin
            cnt_reg <= at_top ? RST_16 : cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            block_reg <= 1'b0;
        end else if (cnt_wr) begin
            block_reg <= 1'b1;
        end else if (tick) begin
            block_reg <= 1'b0;
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_cmp
        assign match_v[i] = tick && !block_reg && (cnt_reg == ocr_reg[i]);
        assign force_v[i] = wr_stb && (addr == A_FORCE) && wdata[B_FOC0-i] && non_pwm;
        assign compare_output_oe[i] = |ctrl_a_reg[7-2*i -: 2];
        always_ff @(posedge core_clk) begin
            if (rst) begin
                oc_reg[i] <= 1'b0;
            end else if ((match_v[i] && non_pwm) || force_v[i]) begin
                case (ctrl_a_reg[7-2*i -: 2])
                    COM_TGL: oc_reg[i] <= !oc_reg[i];
                    COM_CLR: oc_reg[i] <= 1'b0;
                    COM_SET: oc_reg[i] <= 1'b1;
                    default: oc_reg[i] <= oc_reg[i];
                endcase
            end
        end
    end
    assign compare_output_pin = oc_reg;

    // ---------------------------------------------
    // capture path
    // ---------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cap_s1 <= 1'b0;
            cap_s2 <= 1'b0;
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
        end else begin
            cap_s1 <= capture_input_pin;
            cap_s2 <= cap_s1;
            cmp_s1 <= comparator_out;
            cmp_s2 <= cmp_s1;
        end
    end

    assign cap_src = (HAS_CMP_SRC && src_reg) ? cmp_s2 : cap_s2;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hist_reg  <= '0;
            filt_reg  <= 1'b0;
            filt_prev <= 1'b0;
        end else begin
            hist_reg  <= {hist_reg[FILT_N-2:0], cap_src};
            filt_prev <= filt_reg;
            if (!ctrl_b_reg[B_FILT]) begin
                filt_reg <= cap_src;
            end else if (&hist_reg) begin
                filt_reg <= 1'b1;
            end else if (~|hist_reg) begin
                filt_reg <= 1'b0;
            end
        end
    end

    // edge select, disconnected when capture sets top
    assign cap_evt = !icr_top && (ctrl_b_reg[B_EDGE] ? (filt_reg && !filt_prev)
                                                     : (!filt_reg && filt_prev));

    // ---------------------------------------------
    // 16-bit registers and shared latch
    // ---------------------------------------------
    // latch on high write, low read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            temp_reg <= RST_8;
        end else if (wr_stb && addr >= A_CNT_L && addr[0]) begin
            temp_reg <= wdata;
        end else if (rd_stb && addr == A_CNT_L) begin
            temp_reg <= cnt_reg[15:8];
        end else if (rd_stb && addr == A_ICR_L) begin
            temp_reg <= icr_reg[15:8];
        end else if (rd_stb && ocr_lo_rd) begin
            temp_reg <= ocr_hi;
        end
    end

    // compare low-byte read: pick the high byte that the latch keeps
    always_comb begin
        ocr_lo_rd = 1'b0;
        ocr_hi    = RST_8;
        for (int i = 0; i < 3; i++) begin
            if (addr == A_OCR_L + AW'(2*i)) begin
                ocr_lo_rd = 1'b1;
                ocr_hi    = ocr_reg[i][15:8];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            icr_reg <= RST_16;
        end else if (wr_stb && addr == A_ICR_L) begin
            icr_reg <= {temp_reg, wdata};
        end else if (cap_evt) begin
            icr_reg <= cnt_reg;
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_ocr
        always_ff @(posedge core_clk) begin
            if (rst) begin
                ocr_reg[i] <= RST_16;
            end else if (wr_stb && addr == A_OCR_L + AW'(2*i)) begin
                ocr_reg[i] <= {temp_reg, wdata};
            end
        end
    end

    // ---------------------------------------------
    // control registers
    // ---------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_a_reg <= RST_8;
            ctrl_b_reg <= RST_8;
            imsk_reg   <= RST_8;
            src_reg    <= 1'b0;
        end else if (wr_stb) begin
            case (addr)
                A_CTRL_A: ctrl_a_reg <= wdata;
                A_CTRL_B: ctrl_b_reg <= wdata & CTRL_B_WMASK;
                A_IMSK:   imsk_reg   <= wdata & FLAG_MASK;
                A_SRC:    src_reg    <= wdata[0];
                default:  ;
            endcase
        end
    end

    // ---------------------------------------------
    // flags: set wins over clear
    // ---------------------------------------------
    // flag after equality, force never sets
    always_comb begin
        set_v = RST_8;
        set_v[I_OCA+2:I_OCA] = match_v;
        set_v[I_OVF] = tick && (non_pwm ? cnt_reg == TOP_MX : at_top);
        set_v[I_CAP] = cap_evt || (icr_top && tick && at_top);
        clr_v = irq_ack | ((wr_stb && addr == A_FLAG) ? wdata : RST_8);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flag_reg <= RST_8;
        end else begin
            flag_reg <= ((flag_reg & ~clr_v) | set_v) & FLAG_MASK;
        end
    end

    assign irq_req = flag_reg & imsk_reg & {DW{global_irq_enable}};

    // ---------------------------------------------
    // read port
    // ---------------------------------------------
    // force reads zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_reg <= RST_8;
        end else if (rd_stb) begin
            case (addr)
                A_CTRL_A: rdata_reg <= ctrl_a_reg;
                A_CTRL_B: rdata_reg <= ctrl_b_reg;
                A_IMSK:   rdata_reg <= imsk_reg;
                A_FLAG:   rdata_reg <= flag_reg;
                A_SRC:    rdata_reg <= {7'h00, src_reg};
                A_CNT_L:  rdata_reg <= cnt_reg[7:0];
                A_ICR_L:  rdata_reg <= icr_reg[7:0];
                A_OCR_L:  rdata_reg <= ocr_reg[0][7:0];
                4'hc:     rdata_reg <= ocr_reg[1][7:0];
                4'he:     rdata_reg <= ocr_reg[2][7:0];
                A_CNT_H, A_ICR_H, 4'hb, 4'hd, 4'hf: rdata_reg <= temp_reg;
                default:  rdata_reg <= RST_8;
            endcase
        end else begin
            rdata_reg <= RST_8;
        end
    end

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    filt_stable_a: assert property (
        ctrl_b_reg[B_FILT] && $past(ctrl_b_reg[B_FILT]) && $changed(filt_reg)
        |-> $past(hist_reg) == {FILT_N{filt_reg}}) else $error("filter changed early");
    edge_sel_a: assert property (
        cap_evt |-> filt_reg == ctrl_b_reg[B_EDGE]) else $error("wrong capture edge");
    cap_copy_a: assert property (
        cap_evt && !(wr_stb && addr == A_ICR_L) |=> icr_reg == $past(cnt_reg)
        && flag_reg[I_CAP]) else $error("capture not taken");
    cap_off_a: assert property (
        icr_top && !(wr_stb && addr == A_ICR_L)
        |=> $stable(icr_reg)) else $error("capture in top mode");
    stop_hold_a: assert property (
        cs == CS_STOP && !cnt_wr |=> $stable(cnt_reg)) else $error("stopped counter moved");
    ext_rise_a: assert property (
        cs == CS_EXTR && !cnt_wr && !at_top && $rose(ext_s2)
        |=> cnt_reg == $past(cnt_reg) + 1'b1) else $error("rise not counted");
    force_flag_a: assert property (
        |force_v && !(|match_v) && !(wr_stb && addr == A_FLAG)
        |=> $stable(flag_reg[I_OCA+2:I_OCA])) else $error("force set flag");
    force_read_a: assert property (
        rd_stb && addr == A_FORCE |=> rdata == RST_8) else $error("force bits read");
    temp_load_a: assert property (
        rd_stb && addr == A_CNT_L ##1 rd_stb && addr == A_CNT_H
        |=> rdata == $past(cnt_reg[15:8], 2)) else $error("latch mismatch");
    block_cmp_a: assert property (
        cnt_wr ##1 tick |-> match_v == 3'h0) else $error("match not blocked");
    flag_next_a: assert property (
        match_v[0] |=> flag_reg[I_OCA]) else $error("compare flag missing");

    cap_seen_c: cover property (cap_evt ##1 flag_reg[I_CAP]);
    force_seen_c: cover property (|force_v);
    ovf_seen_c: cover property (set_v[I_OVF] ##1 irq_req[I_OVF]);
    ext_seen_c: cover property (cs == CS_EXTF && tick);
endmodule
`default_nettype wire

// *** timer16_capture_compare_regs_test.sv ***
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module timer16_capture_compare_regs_test
    import tcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          core_clk;
    logic          rst;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr_stb;
    logic          rd_stb;
    logic [DW-1:0] rdata;
    logic          cap_pin;
    logic          ext_pin;
    logic          cmp_o;
    logic          gie;
    logic [DW-1:0] irq_ack;
    logic [DW-1:0] irq_req;
    logic [2:0]    oc_pin;
    logic [2:0]    oc_oe;
    int            num_errors;
    int            n_compared;
    logic [31:0]   seed;
    logic [DW-1:0] b;
    logic [CW-1:0] v;
    logic [CW-1:0] mdl_ocr [3];
    int            divs [5] = '{1, 8, 64, 256, 1024};
    tcc_timer16 uut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .capture_input_pin(cap_pin),
        .comparator_out(cmp_o), .external_count_pin(ext_pin), .global_irq_enable(gie),
        .irq_ack(irq_ack), .irq_req(irq_req), .compare_output_pin(oc_pin),
        .compare_output_oe(oc_oe));
    tcc_pins pins (.core_clk(core_clk), .cap_pin(cap_pin), .ext_pin(ext_pin));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        @(negedge core_clk);
        d = rdata;
        @(posedge core_clk);
    endtask
    // high byte into the latch first, low byte commits
    task automatic wr16(input logic [AW-1:0] a, input logic [CW-1:0] d);
        wr(a + 4'h1, d[15:8]);
        wr(a, d[7:0]);
    endtask
    // low read loads the latch, high read follows with no gap
    task automatic rd16(input logic [AW-1:0] a, output logic [CW-1:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        addr <= a + 4'h1;
        @(negedge core_clk);
        d[7:0] = rdata;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        @(negedge core_clk);
        d[15:8] = rdata;
        @(posedge core_clk);
    endtask
    task automatic close_out();
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        close_out();
    end
    initial begin
        {rst, wr_stb, rd_stb, cmp_o, gie} = 5'b10000;
        {addr, wdata, irq_ack} = '0;
        num_errors = 0;
        n_compared = 0;
        seed = 32'd48547;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        // register reset values
        for (int k = 1; k < 5; k++) begin
            rd(AW'(k), b);
            `CHK(b, RST_8);
        end
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            mdl_ocr[k] = seed[15:0];
            wr16(A_OCR_L + AW'(2 * k), mdl_ocr[k]);
        end
        for (int k = 0; k < 3; k++) begin
            rd16(A_OCR_L + AW'(2 * k), v);
            `CHK(v, mdl_ocr[k]);
        end
        // falling edge only, counter stopped so icr is exact
        wr(A_CTRL_B, 8'h00);
        wr16(A_CNT_L, 16'h0abc);
        pins.cap_hold(1'b1, 10);
        rd(A_FLAG, b);
        `CHK(b[I_CAP], 1'b0);
        pins.cap_hold(1'b0, 10);
        rd(A_FLAG, b);
        `CHK(b[I_CAP], 1'b1);
        rd16(A_ICR_L, v);
        `CHK(v, 16'h0abc);
        wr(A_FLAG, FLAG_MASK);
        // filter on, rising edge: a three-sample glitch is dropped
        wr(A_CTRL_B, 8'hc0);
        wr16(A_CNT_L, 16'h0123);
        pins.cap_hold(1'b1, 2);
        pins.cap_hold(1'b0, 12);
        rd(A_FLAG, b);
        `CHK(b[I_CAP], 1'b0);
        pins.cap_hold(1'b1, 4);
        rd(A_FLAG, b);
        `CHK(b[I_CAP], 1'b0);
        repeat (10) @(posedge core_clk);
        rd(A_FLAG, b);
        `CHK(b[I_CAP], 1'b1);
        rd16(A_ICR_L, v);
        `CHK(v, 16'h0123);
        wr(A_FLAG, FLAG_MASK);
        // top taken from icr: pin is disconnected
        wr(A_CTRL_B, 8'h58);
        pins.cap_hold(1'b0, 10);
        pins.cap_hold(1'b1, 10);
        rd(A_FLAG, b);
        `CHK(b[I_CAP], 1'b0);
        rd16(A_ICR_L, v);
        `CHK(v, 16'h0123);
        // comparator as capture source
        wr(A_SRC, 8'h01);
        wr(A_CTRL_B, 8'h40);
        wr16(A_CNT_L, 16'h0777);
        @(posedge core_clk);
        cmp_o <= 1'b1;
        repeat (10) @(posedge core_clk);
        rd(A_FLAG, b);
        `CHK(b[I_CAP], 1'b1);
        rd16(A_ICR_L, v);
        `CHK(v, 16'h0777);
        cmp_o <= 1'b0;
        wr(A_SRC, 8'h00);
        wr(A_FLAG, FLAG_MASK);
        // counter only written while stopped
        // prescaler: six periods give about six counts
        for (int k = 0; k < 5; k++) begin
            wr(A_CTRL_B, {5'h00, CS_STOP});
            wr16(A_CNT_L, 16'h0000);
            wr(A_CTRL_B, {5'h00, 3'(k + 1)});
            repeat (divs[k] * 6) @(posedge core_clk);
            wr(A_CTRL_B, {5'h00, CS_STOP});
            rd16(A_CNT_L, v);
            `CHK(v >= 16'd5 && v <= 16'd8, 1'b1);
        end
        // external pin, both edge codes
        for (int k = 0; k < 2; k++) begin
            wr16(A_CNT_L, 16'h0000);
            wr(A_CTRL_B, {5'h00, k ? CS_EXTR : CS_EXTF});
            pins.ext_pulses(5);
            repeat (4) @(posedge core_clk);
            wr(A_CTRL_B, {5'h00, CS_STOP});
            rd16(A_CNT_L, v);
            `CHK(v, 16'd5);
        end
        // counter written equal to compare a: first tick blocked
        wr16(A_OCR_L, 16'h0100);
        wr16(A_CNT_L, 16'h0100);
        wr(A_FLAG, FLAG_MASK);
        wr(A_CTRL_B, {5'h00, CS_DIV1});
        repeat (10) @(posedge core_clk);
        wr(A_CTRL_B, {5'h00, CS_STOP});
        rd(A_FLAG, b);
        `CHK(b[I_OCA], 1'b0);
        wr16(A_CNT_L, 16'h00f0);
        wr(A_IMSK, 8'h02);
        gie <= 1'b1;
        wr(A_CTRL_B, {5'h00, CS_DIV1});
        repeat (40) @(posedge core_clk);
        wr(A_CTRL_B, {5'h00, CS_STOP});
        rd(A_FLAG, b);
        `CHK(b[I_OCA], 1'b1);
        `CHK(irq_req[I_OCA], 1'b1);
        gie <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK(irq_req[I_OCA], 1'b0);
        gie <= 1'b1;
        irq_ack <= 8'h02;
        @(posedge core_clk);
        irq_ack <= 8'h00;
        rd(A_FLAG, b);
        `CHK(b[I_OCA], 1'b0);
        // forced match toggles pin a in normal mode, no flag
        wr(A_CTRL_A, {COM_TGL, 6'h00});
        repeat (2) @(posedge core_clk);
        v[0] = oc_pin[0];
        `CHK(oc_oe[0], 1'b1);
        wr(A_FORCE, 8'h80);
        repeat (2) @(posedge core_clk);
        `CHK(oc_pin[0], ~v[0]);
        rd(A_FLAG, b);
        `CHK(b, 8'h00);
        `CHK(irq_req, 8'h00);
        rd(A_FORCE, b);
        `CHK(b, 8'h00);
        // pwm mode ignores the strobe
        wr(A_CTRL_A, {COM_TGL, 6'h01});
        wr(A_FORCE, 8'h80);
        repeat (2) @(posedge core_clk);
        `CHK(oc_pin[0], ~v[0]);
        // clear-on-match a: forced set and clear, counter left alone
        wr(A_CTRL_B, 8'h08);
        wr(A_CTRL_A, {COM_SET, 6'h00});
        wr16(A_CNT_L, 16'h0005);
        wr(A_FORCE, 8'h80);
        repeat (2) @(posedge core_clk);
        `CHK(oc_pin[0], 1'b1);
        wr(A_CTRL_A, {COM_CLR, 6'h00});
        wr(A_FORCE, 8'h80);
        repeat (2) @(posedge core_clk);
        `CHK(oc_pin[0], 1'b0);
        rd16(A_CNT_L, v);
        `CHK(v, 16'h0005);
        rd(A_FLAG, b);
        `CHK(b, 8'h00);
        // normal mode overflow at the maximum count
        wr(A_CTRL_B, 8'h00);
        wr(A_CTRL_A, 8'h00);
        wr16(A_CNT_L, 16'hfff0);
        wr(A_IMSK, 8'h01);
        wr(A_CTRL_B, {5'h00, CS_DIV1});
        repeat (20) @(posedge core_clk);
        wr(A_CTRL_B, 8'h00);
        `CHK(irq_req[I_OVF], 1'b1);
        rd(A_FLAG, b);
        `CHK(b[I_OVF], 1'b1);
        close_out();
    end
endmodule
`default_nettype wire
